// ===== common/sasl_params.svh
// constants for the two-wire address and status block: offsets, resets, codes, timing
// assumes an 8-bit special-register port and a 125 MHz system clock
`ifndef SASL_PARAMS_SVH
`define SASL_PARAMS_SVH

`define SASL_STA_OFF        8'hC1
`define SASL_ADR_OFF        8'hC3
`define SASL_STA_RST        8'hF8
`define SASL_ADR_RST        8'h00
`define SASL_GC_BIT         0
`define SASL_RW_BIT         0

`define SASL_C_START        8'h08
`define SASL_C_RSTART       8'h10
`define SASL_C_AW_ACK       8'h18
`define SASL_C_AW_NACK      8'h20
`define SASL_C_DW_ACK       8'h28
`define SASL_C_DW_NACK      8'h30
`define SASL_C_ARB_LOST     8'h38
`define SASL_C_AR_ACK       8'h40
`define SASL_C_AR_NACK      8'h48
`define SASL_C_DR_ACK       8'h50
`define SASL_C_DR_NACK      8'h58
`define SASL_C_IDLE         8'hF8

`define SASL_SYS_CLK_NS     8
`define SASL_SCL_PERIOD_NS  160
`define SASL_QTR_CYC        ((`SASL_SCL_PERIOD_NS / 4 + `SASL_SYS_CLK_NS - 1) / `SASL_SYS_CLK_NS)
`define SASL_FIFO_DEPTH     32

`endif

// ===== common/sasl_pkg.sv
// types shared by the two-wire address and status block
// assumes the constants header is included by the design files
package sasl_pkg;

  // master engine states, gray along idle-start-hold-bit-ack
  typedef enum logic [2:0] {
    M_IDLE   = 3'b000,
    M_START  = 3'b001,
    M_HOLD   = 3'b011,
    M_BIT    = 3'b010,
    M_ACK    = 3'b110,
    M_STOP   = 3'b111,
    M_RSTART = 3'b101
  } sasl_mst_e;

  typedef struct packed {
    logic scl;
    logic sda;
  } sasl_wire_s;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } sasl_sfr_s;

endpackage

// ===== src/sasl_top.sv
// two-wire interface: own address recognition, master engine and status codes
// assumes open-drain pins resolved outside and a 125 MHz single clock
`timescale 1ns/1ps
`default_nettype none
`include "sasl_params.svh"

////////////////////////////////////////////////////////////////////////////////
module sasl_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = `SASL_FIFO_DEPTH
) (
  input  wire logic             clk,       // system clock
  input  wire logic             rst,       // synchronous reset
  input  wire logic             inValid,   // write request
  output var  logic             inReady,   // room available
  input  wire logic [WIDTH-1:0] inData,    // write word
  output var  logic             outValid,  // word available
  input  wire logic             outReady,  // read request
  output var  logic [WIDTH-1:0] outData    // head word
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wp_q, wp_d, rp_q, rp_d;
  logic [AW:0]      cnt_q, cnt_d;
  logic             full_q, full_d, empty_q, empty_d, push, pop;

  always_comb begin
    push    = inValid && !full_q;
    pop     = outReady && !empty_q;
    wp_d    = push ? AW'(wp_q + 1'b1) : wp_q;
    rp_d    = pop ? AW'(rp_q + 1'b1) : rp_q;
    cnt_d   = (AW+1)'(cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop});
    full_d  = (cnt_d == (AW+1)'(DEPTH));
    empty_d = (cnt_d == '0);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wp_q    <= '0;
      rp_q    <= '0;
      cnt_q   <= '0;
      full_q  <= 1'b0;
      empty_q <= 1'b1;
    end else begin
      wp_q    <= wp_d;
      rp_q    <= rp_d;
      cnt_q   <= cnt_d;
      full_q  <= full_d;
      empty_q <= empty_d;
    end
    if (push) begin
      mem[wp_q] <= inData;
    end
  end

  assign inReady  = !full_q;
  assign outValid = !empty_q;
  assign outData  = mem[rp_q];
endmodule

////////////////////////////////////////////////////////////////////////////////
// What this block does
// (RQ1) upper seven address bits hold own slave address, first received bit to top
// (RQ2) address bit zero enables recognition of general call address zero
// (RQ3) own address ignored entirely while acting as bus master
// (RQ4) an eight-bit status code names each condition, each code unique
// (RQ5) low three status bits read zero while the interrupt flag is set
// (RQ6) software reads status only with flag set and never writes it; here a status write lands unless hardware updates the code
// (RQ7) master reports 0x08 after start and 0x10 after repeated start
// (RQ8) address with write: 0x18 when acknowledged, 0x20 when not
// (RQ9) data sent: 0x28 acknowledged, 0x30 not; 0x38 on lost arbitration
// (RQ10) address with read: 0x40 when acknowledged, 0x48 when not
// (RQ11) byte received: 0x50 after sending ack, 0x58 after sending nack
// (RQ12) acknowledge control cleared makes the next received byte get a nack
// (RQ13) software clears stop request before setting start for repeated start
// (RQ14) idle code 0xF8 never sets the flag; every other condition does
// (RQ15) seven received bits compared with own address, eighth is direction
// (RQ16) code changes together with flag set and holds until flag cleared; a software status write still changes it with the flag set
module sasl_top (
  input  wire logic                sys_clk,        // system clock
  input  wire logic                rst,            // synchronous reset
  input  wire sasl_pkg::sasl_sfr_s sfrBus,         // register port request
  output var  logic [7:0]          sfrRdData,      // register read data
  input  wire sasl_pkg::sasl_wire_s pinIn,         // line levels
  output var  sasl_pkg::sasl_wire_s pinOut,        // driven level, always low
  output var  sasl_pkg::sasl_wire_s pinOe,         // pull-low enables
  input  wire logic                beginCondReq,   // start request
  input  wire logic                endCondReq,     // stop request
  input  wire logic                assertAckCtl,   // ack for received bytes
  input  wire logic                siClear,        // clears the flag
  output var  logic                serialIntFlag,  // condition flag
  input  wire logic [7:0]          txData,         // byte to send
  input  wire logic                txValid,        // byte offered
  output var  logic                txReady,        // byte accepted
  output var  logic [7:0]          rxData,         // received byte
  output var  logic                rxValid,        // received byte strobe
  output var  logic                slaveAddrHit,   // own address or general call seen
  output var  logic                generalCallHit, // general call seen
  output var  logic                masterActive    // master engine busy
);
  import sasl_pkg::*;

  localparam logic [9:0] QTR = 10'(`SASL_QTR_CYC - 1);

  function automatic logic ownMatch(input logic [7:0] rx, input logic [7:0] own);
    ownMatch = (rx[7:1] == own[7:1]);
  endfunction

  function automatic logic gcMatch(input logic [7:0] rx, input logic [7:0] own);
    gcMatch = (rx[7:1] == 7'h00) && own[`SASL_GC_BIT];
  endfunction

  sasl_wire_s pinS1_q, pinS2_q, pinP_q, pinOe_q, pinOe_d;
  logic [9:0] div_q, div_d;
  logic       tick;
  sasl_mst_e  st_q, st_d;
  logic [1:0] ph_q, ph_d;
  logic [2:0] bitCnt_q, bitCnt_d;
  logic [7:0] sh_q, sh_d, code_q, code_d, adr_q, adr_d, rx_q, rx_d, rd_q, rd_d;
  logic       isAddr_q, isAddr_d, readDir_q, readDir_d, rxMode_q, rxMode_d;
  logic       aaLatch_q, aaLatch_d, ackSeen_q, ackSeen_d, rep_q, rep_d;
  logic       sclOe_q, sclOe_d, sdaOe_q, sdaOe_d, si_q, si_d, rxV_q, rxV_d;
  logic       mst_q, siSet, codeUpd, arbLost;
  logic       fifoValid, fifoPop;
  logic [7:0] fifoData, statusView;
  logic       busBusy_q, busBusy_d, wAct_q, wAct_d, hit_q, hit_d, gc_q, gc_d;
  logic       slvAck_q, slvAck_d, hitSet, wEval;
  logic [3:0] wCnt_q, wCnt_d;
  logic [7:0] wSh_q, wSh_d;
  logic       startDet, stopDet, sclRise, sclFall;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  sasl_fifo #(.WIDTH(8), .DEPTH(`SASL_FIFO_DEPTH)) txFifo (
    .clk      (sys_clk),
    .rst      (rst),
    .inValid  (txValid),
    .inReady  (txReady),
    .inData   (txData),
    .outValid (fifoValid),
    .outReady (fifoPop),
    .outData  (fifoData)
  );

  //////////////////////////////////////////////////////////////////////////////
  // bus watcher: start/stop detection and own address recognition
  always_comb begin
    startDet  = pinS2_q.scl && pinP_q.scl && pinP_q.sda && !pinS2_q.sda;
    stopDet   = pinS2_q.scl && pinP_q.scl && !pinP_q.sda && pinS2_q.sda;
    sclRise   = pinS2_q.scl && !pinP_q.scl;
    sclFall   = !pinS2_q.scl && pinP_q.scl;
    busBusy_d = busBusy_q;
    wAct_d    = wAct_q;
    wCnt_d    = wCnt_q;
    wSh_d     = wSh_q;
    hit_d     = hit_q;
    gc_d      = gc_q;
    slvAck_d  = slvAck_q;
    wEval     = sclFall && wAct_q && (wCnt_q == 4'd8);
    // (RQ3) master ignores own address
    hitSet    = wEval && !mst_q && (ownMatch(wSh_q, adr_q) || gcMatch(wSh_q, adr_q));
    if (startDet) begin
      busBusy_d = 1'b1;
      wAct_d    = 1'b1;
      wCnt_d    = 4'd0;
      hit_d     = 1'b0;
      gc_d      = 1'b0;
    end else if (stopDet) begin
      busBusy_d = 1'b0;
      wAct_d    = 1'b0;
      hit_d     = 1'b0;
      gc_d      = 1'b0;
      slvAck_d  = 1'b0;
    end else if (sclRise && wAct_q && (wCnt_q < 4'd8)) begin
      // (RQ15) first bit lands in the top position
      wSh_d  = {wSh_q[6:0], pinS2_q.sda};
      wCnt_d = 4'(wCnt_q + 1'b1);
    end else if (wEval) begin
      // (RQ1) (RQ2) address or general call hit
      wAct_d   = 1'b0;
      hit_d    = hitSet;
      gc_d     = hitSet && gcMatch(wSh_q, adr_q);
      slvAck_d = hitSet;
    end else if (sclFall && slvAck_q) begin
      slvAck_d = 1'b0;
    end
  end

  a_gc_gated: assert property (hitSet && wSh_q[7:1] == 7'h00 |-> adr_q[`SASL_GC_BIT]) // RQ2
    else $error("general call accepted while disabled");
  a_addr_match: assert property (hitSet && wSh_q[7:1] != 7'h00 |-> wSh_q[7:1] == adr_q[7:1]) // RQ1
    else $error("slave hit on foreign address");
  a_master_blind: assert property (mst_q |-> !hitSet) // RQ3
    else $error("own address matched while master");

  //////////////////////////////////////////////////////////////////////////////
  // master engine and status code
  always_comb begin
    div_d     = (div_q == QTR) ? 10'h000 : 10'(div_q + 1'b1);
    tick      = (div_q == QTR);
    st_d      = st_q;
    ph_d      = ph_q;
    bitCnt_d  = bitCnt_q;
    sh_d      = sh_q;
    isAddr_d  = isAddr_q;
    readDir_d = readDir_q;
    rxMode_d  = rxMode_q;
    aaLatch_d = aaLatch_q;
    ackSeen_d = ackSeen_q;
    rep_d     = rep_q;
    sclOe_d   = sclOe_q;
    sdaOe_d   = sdaOe_q;
    code_d    = code_q;
    rx_d      = rx_q;
    rxV_d     = 1'b0;
    siSet     = 1'b0;
    codeUpd   = 1'b0;
    arbLost   = 1'b0;
    fifoPop   = 1'b0;
    case (st_q)
      M_IDLE: begin
        sclOe_d = 1'b0;
        sdaOe_d = 1'b0;
        if (tick && beginCondReq && !busBusy_q) begin
          st_d  = M_START;
          ph_d  = 2'd0;
          rep_d = 1'b0;
        end
      end
      M_START: if (tick) begin
        if (ph_q == 2'd0) begin
          sdaOe_d = 1'b1;
          ph_d    = 2'd1;
        end else begin
          // (RQ7) start or repeated start code
          sclOe_d  = 1'b1;
          code_d   = rep_q ? `SASL_C_RSTART : `SASL_C_START;
          codeUpd  = 1'b1;
          siSet    = 1'b1;
          isAddr_d = 1'b1;
          rxMode_d = 1'b0;
          st_d     = M_HOLD;
        end
      end
      M_HOLD: if (tick && !si_q) begin
        ph_d     = 2'd0;
        bitCnt_d = 3'd7;
        if (endCondReq) begin
          st_d = M_STOP;
        end else if (beginCondReq) begin
          st_d = M_RSTART;
        end else if (rxMode_q) begin
          // (RQ12) acknowledge choice taken per received byte
          aaLatch_d = assertAckCtl;
          st_d      = M_BIT;
        end else if (fifoValid) begin
          fifoPop = 1'b1;
          sh_d    = fifoData;
          if (isAddr_q) begin
            readDir_d = fifoData[`SASL_RW_BIT];
          end
          st_d = M_BIT;
        end
      end
      M_BIT: if (tick) begin
        ph_d = 2'(ph_q + 1'b1);
        case (ph_q)
          2'd0: sdaOe_d = !rxMode_q && !sh_q[7];
          2'd1: sclOe_d = 1'b0;
          2'd2: begin
            if (!pinS2_q.scl) begin
              ph_d = ph_q;
            end else if (!rxMode_q && !sdaOe_q && !pinS2_q.sda) begin
              arbLost = 1'b1;
            end else begin
              sh_d = {sh_q[6:0], pinS2_q.sda};
            end
          end
          default: begin
            sclOe_d = 1'b1;
            if (bitCnt_q == 3'd0) begin
              st_d = M_ACK;
            end else begin
              bitCnt_d = 3'(bitCnt_q - 1'b1);
            end
          end
        endcase
        if (arbLost) begin
          // (RQ9) arbitration lost releases the bus
          st_d    = M_IDLE;
          sclOe_d = 1'b0;
          sdaOe_d = 1'b0;
          code_d  = `SASL_C_ARB_LOST;
          codeUpd = 1'b1;
          siSet   = 1'b1;
        end
      end
      M_ACK: if (tick) begin
        ph_d = 2'(ph_q + 1'b1);
        case (ph_q)
          2'd0: sdaOe_d = rxMode_q && aaLatch_q;
          2'd1: sclOe_d = 1'b0;
          2'd2: begin
            if (pinS2_q.scl) begin
              ackSeen_d = !pinS2_q.sda;
            end else begin
              ph_d = ph_q;
            end
          end
          default: begin
            sclOe_d = 1'b1;
            sdaOe_d = 1'b0;
            st_d    = M_HOLD;
            siSet   = 1'b1;
            codeUpd = 1'b1;
            // (RQ8) (RQ10) address codes, (RQ9) (RQ11) data codes
            if (isAddr_q) begin
              if (readDir_q) begin
                code_d = ackSeen_q ? `SASL_C_AR_ACK : `SASL_C_AR_NACK;
              end else begin
                code_d = ackSeen_q ? `SASL_C_AW_ACK : `SASL_C_AW_NACK;
              end
              rxMode_d = readDir_q && ackSeen_q;
            end else if (rxMode_q) begin
              code_d = aaLatch_q ? `SASL_C_DR_ACK : `SASL_C_DR_NACK;
              rx_d   = sh_q;
              rxV_d  = 1'b1;
            end else begin
              code_d = ackSeen_q ? `SASL_C_DW_ACK : `SASL_C_DW_NACK;
            end
            isAddr_d = 1'b0;
          end
        endcase
      end
      M_STOP: if (tick) begin
        ph_d = 2'(ph_q + 1'b1);
        case (ph_q)
          2'd0: sdaOe_d = 1'b1;
          2'd1: sclOe_d = 1'b0;
          2'd2: begin
            if (pinS2_q.scl) begin
              sdaOe_d = 1'b0;
            end else begin
              ph_d = ph_q;
            end
          end
          default: begin
            // (RQ14) idle code without the flag
            st_d    = M_IDLE;
            code_d  = `SASL_C_IDLE;
            codeUpd = 1'b1;
          end
        endcase
      end
      M_RSTART: if (tick) begin
        ph_d = 2'(ph_q + 1'b1);
        case (ph_q)
          2'd0: sdaOe_d = 1'b0;
          2'd1: sclOe_d = 1'b0;
          2'd2: if (!pinS2_q.scl) ph_d = ph_q;
          default: begin
            sdaOe_d = 1'b1;
            rep_d   = 1'b1;
            ph_d    = 2'd1;
            st_d    = M_START;
          end
        endcase
      end
      default: st_d = M_IDLE;
    endcase
    // (RQ16) a new event sets the flag, set beats clear
    si_d = siSet || (si_q && !siClear);
    // (RQ6) software write lands only when hardware is not updating
    if (sfrBus.wr && sfrBus.addr == `SASL_STA_OFF && !codeUpd) begin
      code_d = sfrBus.wdata;
    end
    adr_d = (sfrBus.wr && sfrBus.addr == `SASL_ADR_OFF) ? sfrBus.wdata : adr_q;
    // (RQ4) (RQ5) low bits masked while flag set
    statusView = si_q ? {code_q[7:3], 3'b000} : code_q;
    rd_d = rd_q;
    if (sfrBus.rd) begin
      rd_d = (sfrBus.addr == `SASL_STA_OFF) ? statusView :
             (sfrBus.addr == `SASL_ADR_OFF) ? adr_q : 8'h00;
    end
    pinOe_d.scl = sclOe_d;
    pinOe_d.sda = sdaOe_d || slvAck_d;
  end

  a_low_bits: assert property (sfrBus.rd && sfrBus.addr == `SASL_STA_OFF && si_q // RQ5
      |=> sfrRdData[2:0] == 3'b000)
    else $error("status low bits not zero with flag set");
  a_idle_no_flag: assert property ($rose(si_q) |-> code_q != `SASL_C_IDLE) // RQ14
    else $error("idle code raised the flag");
  a_code_holds: assert property (si_q && $past(si_q) && !$past(siSet)
      && !$past(sfrBus.wr) |-> code_q == $past(code_q)) // RQ16
    else $error("status code moved while flag set");
  a_start_code: assert property ($rose(si_q) && $past(st_q) == M_START
      |-> code_q == ($past(rep_q) ? `SASL_C_RSTART : `SASL_C_START)) // RQ7
    else $error("wrong start code");
  a_write_addr: assert property (siSet && st_q == M_ACK && isAddr_q && !readDir_q
      |=> code_q == (ackSeen_q ? `SASL_C_AW_ACK : `SASL_C_AW_NACK) [*1]) // RQ8
    else $error("wrong write-address code");
  a_read_addr: assert property (siSet && st_q == M_ACK && isAddr_q && readDir_q
      |=> si_q && code_q == ($past(ackSeen_q) ? `SASL_C_AR_ACK : `SASL_C_AR_NACK)) // RQ10
    else $error("wrong read-address code");
  a_arb_code: assert property (arbLost |=> si_q && code_q == `SASL_C_ARB_LOST
      && !pinOe_q.scl) // RQ9
    else $error("arbitration loss not reported");
  a_rx_code: assert property (rxV_q |-> si_q && (code_q == `SASL_C_DR_ACK
      || code_q == `SASL_C_DR_NACK)) // RQ11
    else $error("receive strobe without receive code");
  a_rx_nack: assert property (st_q == M_ACK && rxMode_q && !aaLatch_q && !slvAck_q
      |-> !pinOe_q.sda) // RQ12
    else $error("ack driven with ack control cleared");
  c_start: cover property ($rose(si_q) && code_q == `SASL_C_START);
  c_read_nack: cover property ($rose(si_q) && code_q == `SASL_C_DR_NACK);
  c_slave_hit: cover property ($rose(hit_q));
  c_fifo_full: cover property (txValid && !txReady);

  //////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge sys_clk) begin
    pinS1_q <= pinIn;
    pinS2_q <= pinS1_q;
    if (rst) begin
      pinP_q    <= '1;
      div_q     <= 10'h000;
      st_q      <= M_IDLE;
      ph_q      <= 2'd0;
      bitCnt_q  <= 3'd0;
      sh_q      <= 8'h00;
      isAddr_q  <= 1'b0;
      readDir_q <= 1'b0;
      rxMode_q  <= 1'b0;
      aaLatch_q <= 1'b0;
      ackSeen_q <= 1'b0;
      rep_q     <= 1'b0;
      sclOe_q   <= 1'b0;
      sdaOe_q   <= 1'b0;
      si_q      <= 1'b0;
      code_q    <= `SASL_STA_RST;
      adr_q     <= `SASL_ADR_RST;
      rx_q      <= 8'h00;
      rxV_q     <= 1'b0;
      rd_q      <= 8'h00;
      mst_q     <= 1'b0;
      pinOe_q   <= '0;
      busBusy_q <= 1'b0;
      wAct_q    <= 1'b0;
      wCnt_q    <= 4'd0;
      wSh_q     <= 8'h00;
      hit_q     <= 1'b0;
      gc_q      <= 1'b0;
      slvAck_q  <= 1'b0;
    end else begin
      pinP_q    <= pinS2_q;
      div_q     <= div_d;
      st_q      <= st_d;
      ph_q      <= ph_d;
      bitCnt_q  <= bitCnt_d;
      sh_q      <= sh_d;
      isAddr_q  <= isAddr_d;
      readDir_q <= readDir_d;
      rxMode_q  <= rxMode_d;
      aaLatch_q <= aaLatch_d;
      ackSeen_q <= ackSeen_d;
      rep_q     <= rep_d;
      sclOe_q   <= sclOe_d;
      sdaOe_q   <= sdaOe_d;
      si_q      <= si_d;
      code_q    <= code_d;
      adr_q     <= adr_d;
      rx_q      <= rx_d;
      rxV_q     <= rxV_d;
      rd_q      <= rd_d;
      mst_q     <= (st_d != M_IDLE);
      pinOe_q   <= pinOe_d;
      busBusy_q <= busBusy_d;
      wAct_q    <= wAct_d;
      wCnt_q    <= wCnt_d;
      wSh_q     <= wSh_d;
      hit_q     <= hit_d;
      gc_q      <= gc_d;
      slvAck_q  <= slvAck_d;
    end
  end

  assign sfrRdData      = rd_q;
  assign pinOut         = '0;
  assign pinOe          = pinOe_q;
  assign serialIntFlag  = si_q;
  assign rxData         = rx_q;
  assign rxValid        = rxV_q;
  assign slaveAddrHit   = hit_q;
  assign generalCallHit = gc_q;
  assign masterActive   = mst_q;
endmodule
`default_nettype wire

// ===== tb/sasl_slave_model.sv
// partner model: a slave on the two-wire bus that acks its own address
// assumes resolved line levels with pull-ups; it only ever pulls data low
`timescale 1ns/1ps
`default_nettype none
module sasl_slave_model #(
  parameter logic [6:0] ADDR  = 7'h2A, // address answered
  parameter logic [7:0] RDATA = 8'hA5  // byte returned on reads
) (
  input  wire logic scl,     // resolved clock line
  input  wire logic sda,     // resolved data line
  output var  logic pullSda  // high while pulling data low
);
  logic [7:0] sh;
  int         cnt;
  logic       rd;
  logic       act;
  logic       first;
  initial begin
    pullSda = 1'b0;
    cnt = 0;
    act = 1'b0;
    first = 1'b0;
  end
  // start seen: next byte is an address
  always @(negedge sda) begin
    if (scl === 1'b1) begin
      cnt = 0;
      first = 1'b1;
      act = 1'b0;
    end
  end
  always @(posedge scl) begin
    sh = {sh[6:0], sda};
    cnt = cnt + 1;
  end
  // data changes only while the clock is low; written 0xFF is refused
  always @(negedge scl) begin
    pullSda = 1'b0;
    if (cnt == 9)
      cnt = 0;
    if (cnt == 8 && first) begin
      act = (sh[7:1] == ADDR);
      rd = sh[0];
      first = 1'b0;
      pullSda = act;
    end else if (cnt == 8)
      pullSda = act && !rd && sh != 8'hFF;
    else if (act && rd && !first)
      pullSda = !RDATA[7-cnt];
  end
endmodule
`default_nettype wire

// ===== tb/tb.sv
// testbench: master transfers against the slave model, status codes read back
// assumes the full-rate link timing of the design's constants header
`timescale 1ns/1ps
`default_nettype none
module tb;
  import sasl_pkg::*;
  logic       sys_clk = 1'b0;
  logic       rst = 1'b1;
  sasl_sfr_s  sfrBus = '0;
  logic [7:0] sfrRdData;
  sasl_wire_s pinIn;
  sasl_wire_s pinOut;
  sasl_wire_s pinOe;
  logic       beginCondReq = 1'b0;
  logic       endCondReq = 1'b0;
  logic       assertAckCtl = 1'b1;
  logic       siClear = 1'b0;
  logic       serialIntFlag;
  logic [7:0] txData = 8'h00;
  logic       txValid = 1'b0;
  logic       txReady;
  logic [7:0] rxData;
  logic       rxValid;
  logic       slaveAddrHit;
  logic       generalCallHit;
  logic       masterActive;
  logic       pullSda;
  logic       extScl = 1'b0;
  logic       extSda = 1'b0;
  logic [7:0] d;
  int         bad_count = 0;
  int         n_checks = 0;
  int         n;
  always #4 sys_clk = ~sys_clk;
  // open-drain lines with pull-ups
  assign pinIn = {!(pinOe.scl || extScl), !(pinOe.sda || pullSda || extSda)};
  sasl_top dut (.sys_clk(sys_clk), .rst(rst), .sfrBus(sfrBus), .sfrRdData(sfrRdData),
    .pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe), .beginCondReq(beginCondReq),
    .endCondReq(endCondReq), .assertAckCtl(assertAckCtl), .siClear(siClear),
    .serialIntFlag(serialIntFlag), .txData(txData), .txValid(txValid), .txReady(txReady),
    .rxData(rxData), .rxValid(rxValid), .slaveAddrHit(slaveAddrHit),
    .generalCallHit(generalCallHit), .masterActive(masterActive));
  sasl_slave_model slv (.scl(pinIn.scl), .sda(pinIn.sda), .pullSda(pullSda));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic final_report();
    if (bad_count == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic access(input logic w, input logic [7:0] a, input logic [7:0] wd);
    @(negedge sys_clk);
    sfrBus = '{wr: w, rd: !w, addr: a, wdata: wd};
    @(negedge sys_clk);
    sfrBus = '0;
    d = sfrRdData;
  endtask
  task automatic push(input logic [7:0] b);
    @(negedge sys_clk);
    txValid = 1'b1;
    txData = b;
    @(negedge sys_clk);
    txValid = 1'b0;
  endtask
  task automatic go();
    @(negedge sys_clk);
    siClear = 1'b1;
    @(negedge sys_clk);
    siClear = 1'b0;
  endtask
  // wait for the flag, then read the status code
  task automatic step(input logic [7:0] exp);
    for (n = 0; n < 20000 && serialIntFlag !== 1'b1; n++)
      @(negedge sys_clk);
    if (n >= 20000) begin
      bad_count++;
      final_report();
    end
    access(1'b0, 8'hC1, 8'h00); // status read only with flag set
    check(d, exp);
  endtask
  // a second master on the bus: start and one address byte, ending in the ack slot
  task automatic ext_addr(input logic [7:0] b);
    extSda = 1'b1;
    repeat (10) @(negedge sys_clk);
    for (int i = 7; i >= 0; i--) begin
      extScl = 1'b1;
      repeat (5) @(negedge sys_clk);
      extSda = !b[i];
      repeat (5) @(negedge sys_clk);
      extScl = 1'b0;
      repeat (10) @(negedge sys_clk);
    end
    extScl = 1'b1;
    repeat (5) @(negedge sys_clk);
    extSda = 1'b0;
    repeat (5) @(negedge sys_clk);
  endtask
  // ack clock pulse, then stop
  task automatic ext_stop();
    extScl = 1'b0;
    repeat (10) @(negedge sys_clk);
    extScl = 1'b1;
    repeat (5) @(negedge sys_clk);
    extSda = 1'b1;
    repeat (5) @(negedge sys_clk);
    extScl = 1'b0;
    repeat (10) @(negedge sys_clk);
    extSda = 1'b0;
    repeat (10) @(negedge sys_clk);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (3) @(negedge sys_clk);
    rst = 1'b0;
    access(1'b0, 8'hC1, 8'h00);
    check(d, 8'hF8); // idle code
    access(1'b0, 8'hC3, 8'h00);
    check(d, 8'h00); // reset value
    access(1'b0, 8'h00, 8'h00);
    check(d, 8'h00); // unmapped
    access(1'b1, 8'hC3, 8'h55);
    access(1'b0, 8'hC3, 8'h00);
    check(d, 8'h55); // address register
    beginCondReq = 1'b1;
    step(8'h08); // start
    beginCondReq = 1'b0;
    push(8'h54);
    go();
    step(8'h18); // address ack
    check({7'h00, slaveAddrHit}, 8'h00); // own address ignored
    push(8'h3C);
    go();
    step(8'h28); // data ack
    push(8'hFF);
    go();
    step(8'h30); // data nack
    beginCondReq = 1'b1;
    go();
    step(8'h10); // repeated start
    beginCondReq = 1'b0;
    push(8'h55);
    go();
    step(8'h40); // read address ack
    go();
    step(8'h50); // byte acked
    check(rxData, 8'hA5); // received byte
    assertAckCtl = 1'b0;
    go();
    step(8'h58); // last byte nacked
    beginCondReq = 1'b1;
    go();
    step(8'h10); // repeated start
    beginCondReq = 1'b0;
    push(8'h22);
    go();
    step(8'h20); // address nack
    access(1'b0, 8'hC1, 8'h00);
    step(8'h20); // code holds
    endCondReq = 1'b1;
    go();
    for (n = 0; n < 5000 && masterActive !== 1'b0; n++)
      @(negedge sys_clk);
    if (n >= 5000) begin
      bad_count++;
      final_report();
    end
    endCondReq = 1'b0;
    repeat (20) @(negedge sys_clk);
    check({7'h00, serialIntFlag}, 8'h00); // idle sets no flag
    access(1'b0, 8'hC1, 8'h00);
    check(d, 8'hF8); // idle code
    check({7'h00, masterActive}, 8'h00); // engine idle after stop
    ext_addr(8'h00);
    check({6'h00, generalCallHit, slaveAddrHit}, 8'h03); // general call seen
    check({7'h00, pinOe.sda}, 8'h01); // address byte acked
    ext_stop();
    check({7'h00, slaveAddrHit}, 8'h00); // hit dropped at stop
    access(1'b1, 8'hC3, 8'h54);
    ext_addr(8'h00);
    check({6'h00, generalCallHit, slaveAddrHit}, 8'h00); // general call ignored
    check({7'h00, pinOe.sda}, 8'h00); // no ack for ignored call
    ext_stop();
    ext_addr(8'h54);
    check({6'h00, generalCallHit, slaveAddrHit}, 8'h01); // own address seen
    check({7'h00, pinOe.sda}, 8'h01); // own address acked
    ext_stop();
    beginCondReq = 1'b1;
    step(8'h08); // start again
    beginCondReq = 1'b0;
    push(8'hFF);
    extSda = 1'b1;
    go();
    step(8'h38); // arbitration lost
    extSda = 1'b0;
    check({7'h00, masterActive}, 8'h00); // bus released
    final_report();
  end
endmodule
`default_nettype wire
